// >>> monitor_consts.vh
// constants for the shared-cache monitor readout block
// assumes includers use the macros as bit positions, widths and reset values
`ifndef MONITOR_CONSTS_VH
`define MONITOR_CONSTS_VH

`define REG_ADDR_W 2
`define ADDR_EVENT_SELECT 2'h0
`define ADDR_COUNT_READOUT 2'h1
`define ADDR_TAG_ASSOC 2'h2

`define EVT_CODE_MSB 7
`define EVT_CODE_LSB 0
`define EVT_CODE_W 8
`define TAG_MSB 41
`define TAG_LSB 32
`define TAG_W 10
`define NUM_TAGS 1024

`define CTR_ERROR_BIT 63
`define CTR_UNAVAIL_BIT 62
`define CTR_DATA_MSB 61
`define CTR_DATA_W 62

`define EVT_OCCUPANCY 8'h01
`define EVT_TOTAL_BW 8'h02
`define EVT_LOCAL_BW 8'h03

`define SELECT_WRITABLE_MASK 64'h0000_03FF_0000_00FF
`define ASSOC_WRITABLE_MASK 64'h0000_0000_0000_03FF
`define SELECT_RESET 64'h0000_0000_0000_0000
`define ASSOC_RESET 64'h0000_0000_0000_0000
`define HIGHEST_TAG_DEFAULT 10'h3FF
`define GP_ERROR_CODE 16'h0000

`endif

// >>> monitor_tag_store.v
// per-tag count storage, one 62-bit word per tag and event, plus availability
// assumes the cache side writes samples at most once per cycle
`timescale 1ns/1ps
`default_nettype none
`include "monitor_consts.vh"

module monitor_tag_store (
  input wire ref_clk, // core clock
  input wire rst, // synchronous reset, active high
  input wire sampleValid, // cache side presents a new sample
  input wire [1:0] sampleEvent, // 0 occupancy, 1 total bw, 2 local bw
  input wire [`TAG_W-1:0] sampleTag, // tag of the sample
  input wire [`CTR_DATA_W-1:0] sampleCount, // sampled count
  input wire [1:0] rdEvent, // event index to read
  input wire [`TAG_W-1:0] rdTag, // tag to read
  output wire [`CTR_DATA_W-1:0] rdCount, // stored count
  output wire rdAvail // a sample exists for this tag and event
);
  reg [`CTR_DATA_W-1:0] countMem_reg [0:3*`NUM_TAGS-1];
  reg [3*`NUM_TAGS-1:0] availMem_reg;

  function [11:0] slot;
    input [1:0] ev;
    input [`TAG_W-1:0] tag;
    begin
      slot = {ev, tag};
    end
  endfunction

  // counts are held until a newer sample arrives, never cleared by other events
  // a newer sample simply overwrites, so power-state shrink or flush shows up here
  always @(posedge ref_clk)
  begin
    if (sampleValid && sampleEvent != 2'h3)
    begin
      countMem_reg[slot(sampleEvent, sampleTag)] <= sampleCount;
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
      availMem_reg <= {3*`NUM_TAGS{1'b0}};
    else if (sampleValid && sampleEvent != 2'h3)
      availMem_reg[slot(sampleEvent, sampleTag)] <= 1'b1;
  end

  assign rdCount = countMem_reg[slot(rdEvent, rdTag)];
  assign rdAvail = (rdEvent != 2'h3) && availMem_reg[slot(rdEvent, rdTag)];
endmodule // monitor_tag_store

`default_nettype wire

// >>> monitor_write_check.v
// write legality check for the select and association registers
// assumes highestTag is stable while a write is presented
`timescale 1ns/1ps
`default_nettype none
`include "monitor_consts.vh"

module monitor_write_check (
  input wire [63:0] wrData, // value being written
  input wire [63:0] oldValue, // current register contents
  input wire [63:0] writableMask, // bits that software may change
  input wire [`TAG_W-1:0] newTag, // tag field of the written value
  input wire [`TAG_W-1:0] highestTag, // largest supported tag
  output wire reservedFault, // a reserved bit would change
  output wire tagFault // tag above highest supported
);
  assign reservedFault = |((wrData ^ oldValue) & ~writableMask);
  assign tagFault = newTag > highestTag;
endmodule // monitor_write_check

`default_nettype wire

// >>> scm_readout_monitor.sv
// assertions on the readout register port
// assumes a bind to shared_cache_monitor_readout
`timescale 1ns/1ps
`default_nettype none
module scm_monitor (
  input wire ref_clk, // clock
  input wire rst, // reset
  input wire regRead, // read
  input wire regWrite, // write
  input wire [1:0] regAddr, // address
  input wire [63:0] regWrData, // wdata
  input wire [63:0] regRdData, // rdata
  input wire regAck, // ack
  input wire gpFault, // fault
  input wire [15:0] gpErrorCode, // code
  input wire [9:0] highestTag, // limit
  input wire [9:0] activeTag // tag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_ctr_read;
    regRead && !regWrite && regAddr == 2'h1;
  endsequence
  a_ack_follows: assert property ((regRead || regWrite) |=> regAck)
    else $error("access not acknowledged");
  a_fault_code: assert property (gpFault |-> regAck && gpErrorCode == 16'h0000)
    else $error("fault without ack or with nonzero code");
  a_ro_write: assert property (regWrite && regAddr == 2'h1 |=> gpFault)
    else $error("readout write accepted");
  a_sel_tag: assert property (regWrite && regAddr == 2'h0 && regWrData[41:32] > highestTag
    |=> gpFault) else $error("select tag over limit accepted");
  a_rsvd_bits: assert property (regWrite && regAddr == 2'h2 && regWrData[63:10] != 54'h0
    |=> gpFault) else $error("association reserved bits accepted");
  a_err_zero: assert property ((s_ctr_read ##1 regRdData[63]) |-> regRdData[62:0] == 63'h0)
    else $error("error readout carries data");
  a_unav_zero: assert property ((s_ctr_read ##1 regRdData[62]) |-> regRdData[61:0] == 62'h0)
    else $error("unavailable readout carries data");
  a_tag_hold: assert property (!$past(regWrite) |-> $stable(activeTag))
    else $error("tag moved without a write");
endmodule // scm_monitor
bind shared_cache_monitor_readout scm_monitor i_scm_monitor (.ref_clk, .rst, .regRead,
  .regWrite, .regAddr, .regWrData, .regRdData, .regAck, .gpFault, .gpErrorCode, .highestTag,
  .activeTag);
`default_nettype wire

// >>> shared_cache_monitor_readout.v
// register readout for per-tag shared-resource monitoring, model-register style port
// assumes one register access per cycle; samples come from the cache side, whose
// counts already reflect power-state shrinking and flushes
`timescale 1ns/1ps
`default_nettype none
`include "monitor_consts.vh"

module shared_cache_monitor_readout (
  input wire ref_clk, // core clock, 20 MHz
  input wire rst, // synchronous reset, active high
  input wire regRead, // model_register_read strobe
  input wire regWrite, // model_register_write strobe
  input wire [`REG_ADDR_W-1:0] regAddr, // register select
  input wire [63:0] regWrData, // write data
  output reg [63:0] regRdData, // read data, registered
  output reg regAck, // one-cycle completion pulse
  output reg gpFault, // one-cycle protection fault pulse
  output reg [15:0] gpErrorCode, // fault error code
  input wire [`TAG_W-1:0] highestTag, // largest supported tag
  input wire smiActive, // system management interrupt in service
  input wire sampleValid, // cache side sample strobe
  input wire [1:0] sampleEvent, // sample event index
  input wire [`TAG_W-1:0] sampleTag, // sample tag
  input wire [`CTR_DATA_W-1:0] sampleCount, // sample count
  output wire [`TAG_W-1:0] activeTag // tag driven to the cache for tagging
);
  reg [63:0] selectReg_reg;
  reg [63:0] selectReg_next;
  reg [63:0] assocReg_reg;
  reg [63:0] assocReg_next;
  reg [63:0] rdData_next;
  reg ack_next;
  reg fault_next;

  wire [`EVT_CODE_W-1:0] selCode;
  wire [`TAG_W-1:0] selTag;
  wire [1:0] selIndex;
  wire [2:0] selDecode;
  wire codeOk;
  wire tagOk;
  wire [`CTR_DATA_W-1:0] storedCount;
  wire storedAvail;
  wire [63:0] readoutValue;
  wire [63:0] checkOld;
  wire [63:0] checkMask;
  wire [`TAG_W-1:0] checkTag;
  wire resFault;
  wire tagFault;
  wire checkedReg;

  // map supported event codes to storage slots; anything else is reserved
  function [2:0] decode_event;
    input [`EVT_CODE_W-1:0] code;
    begin
      case (code)
        `EVT_OCCUPANCY: decode_event = 3'b100;
        `EVT_TOTAL_BW: decode_event = 3'b101;
        `EVT_LOCAL_BW: decode_event = 3'b110;
        default: decode_event = 3'b011;
      endcase
    end
  endfunction

  assign selCode = selectReg_reg[`EVT_CODE_MSB:`EVT_CODE_LSB];
  assign selTag = selectReg_reg[`TAG_MSB:`TAG_LSB];
  assign selDecode = decode_event(selCode);
  assign codeOk = selDecode[2];
  assign selIndex = selDecode[1:0];
  // tags are package-wide, so any tag up to the highest is legal here
  assign tagOk = selTag <= highestTag;
  assign activeTag = assocReg_reg[`TAG_W-1:0];

  // separate storage from any general counters, so both can run at once
  monitor_tag_store u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .sampleValid(sampleValid),
    .sampleEvent(sampleEvent),
    .sampleTag(sampleTag),
    .sampleCount(sampleCount),
    .rdEvent(selIndex),
    .rdTag(selTag),
    .rdCount(storedCount),
    .rdAvail(storedAvail)
  );

  // readout is computed from the live select value at read time
  assign readoutValue = (!(codeOk && tagOk)) ? 64'h8000_0000_0000_0000 :
    (!storedAvail) ? 64'h4000_0000_0000_0000 :
    {2'b00, storedCount};

  assign checkedReg = (regAddr == `ADDR_EVENT_SELECT) || (regAddr == `ADDR_TAG_ASSOC);
  assign checkOld = (regAddr == `ADDR_TAG_ASSOC) ? assocReg_reg : selectReg_reg;
  assign checkMask = (regAddr == `ADDR_TAG_ASSOC) ?
    `ASSOC_WRITABLE_MASK : `SELECT_WRITABLE_MASK;
  assign checkTag = (regAddr == `ADDR_TAG_ASSOC) ?
    regWrData[`TAG_W-1:0] : regWrData[`TAG_MSB:`TAG_LSB];

  monitor_write_check u_check (
    .wrData(regWrData),
    .oldValue(checkOld),
    .writableMask(checkMask),
    .newTag(checkTag),
    .highestTag(highestTag),
    .reservedFault(resFault),
    .tagFault(tagFault)
  );

  // smiActive is deliberately not used to touch state: contents survive handler runs
  always @*
  begin
    selectReg_next = selectReg_reg;
    assocReg_next = assocReg_reg;
    rdData_next = regRdData;
    ack_next = 1'b0;
    fault_next = 1'b0;
    if (regWrite)
    begin
      ack_next = 1'b1;
      if (!checkedReg)
        fault_next = 1'b1;
      else if (resFault || tagFault)
        fault_next = 1'b1;
      else if (regAddr == `ADDR_EVENT_SELECT)
        selectReg_next = regWrData;
      else
        assocReg_next = regWrData;
    end
    else if (regRead)
    begin
      ack_next = 1'b1;
      case (regAddr)
        `ADDR_EVENT_SELECT: rdData_next = selectReg_reg;
        `ADDR_COUNT_READOUT: rdData_next = readoutValue;
        `ADDR_TAG_ASSOC: rdData_next = assocReg_reg;
        default:
        begin
          rdData_next = 64'h0000_0000_0000_0000;
          fault_next = 1'b1;
        end
      endcase
    end
  end

  // no interrupt output exists; fault is only the access answer
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      selectReg_reg <= `SELECT_RESET;
      assocReg_reg <= `ASSOC_RESET;
      regRdData <= 64'h0000_0000_0000_0000;
      regAck <= 1'b0;
      gpFault <= 1'b0;
      gpErrorCode <= `GP_ERROR_CODE;
    end
    else
    begin
      selectReg_reg <= selectReg_next;
      assocReg_reg <= assocReg_next;
      regRdData <= rdData_next;
      regAck <= ack_next;
      gpFault <= fault_next;
      gpErrorCode <= `GP_ERROR_CODE;
    end
  end
endmodule // shared_cache_monitor_readout

`default_nettype wire

// >>> sw_master.sv
// software side model issuing register accesses
// assumes each call starts just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module sw_master (
  input wire ref_clk, // clock
  output logic regRead, // read
  output logic regWrite, // write
  output logic [1:0] regAddr, // address
  output logic [63:0] regWrData // wdata
);
  initial {regRead, regWrite, regAddr, regWrData} = '0;
  task automatic acc(logic wr, logic [1:0] a, logic [63:0] d);
    {regWrite, regRead, regAddr, regWrData} = {wr, !wr, a, d};
    @(posedge ref_clk) #1 {regRead, regWrite} = 2'b00;
    regWrData = ~d; // a released bus must not keep looking valid
    @(posedge ref_clk) #1; // return after the answer, so accesses never overlap
  endtask
endmodule // sw_master
`default_nettype wire

// >>> tb_shared_cache_monitor_readout.sv
// self-checking bench for the monitor readout registers
// assumes sw_master paces every register access
`timescale 1ns/1ps
`default_nettype none
module tb_shared_cache_monitor_readout;
  localparam logic [63:0] errFlag = 64'h8000_0000_0000_0000, unavFlag = 64'h4000_0000_0000_0000;
  logic refClk = 1'b0, regRead, regWrite, rst = 1'b1, smiActive = 1'b0;
  logic regAck, gpFault, sampleValid = 1'b0;
  logic seenAck = 1'b0, seenFault = 1'b0;
  logic [63:0] seenRd = 64'h0000_0000_0000_0000;
  logic [1:0] regAddr, sampleEvent = 2'h0;
  logic [63:0] regWrData, regRdData;
  logic [9:0] activeTag, highestTag = 10'h3FF, sampleTag = 10'h005;
  logic [61:0] sampleCount = {31'h7FFF_FFFF, 31'h0000_1234};
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  shared_cache_monitor_readout i_shared_cache_monitor_readout (.ref_clk(refClk), .rst,
    .regRead, .regWrite, .regAddr, .regWrData, .regRdData, .regAck, .gpFault, .gpErrorCode(),
    .highestTag, .smiActive, .sampleValid, .sampleEvent, .sampleTag, .sampleCount, .activeTag);
  sw_master i_sw_master (.ref_clk(refClk), .regRead, .regWrite, .regAddr, .regWrData);
  initial forever #25 refClk = ~refClk;
  // ack and fault stand for one cycle only, read data until the next read; keep what stood before each edge
  always @(posedge refClk)
  begin
    seenAck <= regAck;
    seenFault <= gpFault;
    seenRd <= regRdData;
  end
  task chk(string what, logic [63:0] seen, exp);
    total_checks++;
    n_mismatch += int'(seen !== exp);
    if (seen !== exp)
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
  endtask
  task xfer(logic wr, logic [1:0] a, logic [63:0] d, e, logic f);
    i_sw_master.acc(wr, a, d);
    chk("ack fault", {62'h0, seenAck, seenFault}, {62'h0, 1'b1, f});
    if (!wr)
      chk("rdata", seenRd, e);
  endtask
  task test_done(logic hung);
    n_mismatch += int'(hung);
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task t_codes;
    xfer(0, 2'h0, 64'h0, 64'h0, 0);
    xfer(0, 2'h1, 64'h0, errFlag, 0);
    for (int c = 1; c < 5; c++)
    begin
      xfer(1, 2'h0, {22'h0, sampleTag, 24'h0, c[7:0]}, 64'h0, 0);
      xfer(0, 2'h1, 64'h0, c < 4 ? unavFlag : errFlag, 0);
      {sampleValid, sampleEvent} = {1'b1, 2'(c - 1)};
      @(posedge refClk) #1 sampleValid = 1'b0;
      xfer(0, 2'h1, 64'h0, c < 4 ? {2'b00, sampleCount} : errFlag, 0);
    end
  endtask
  task t_refuse;
    {highestTag, smiActive} = {10'h00F, 1'b1};
    xfer(1, 2'h2, 64'h010, 64'h0, 1);
    xfer(1, 2'h0, 64'h0000_0010_0000_0001, 64'h0, 1);
    xfer(1, 2'h0, 64'h0000_000F_0000_0101, 64'h0, 1);
    xfer(1, 2'h2, 64'h40F, 64'h0, 1);
    xfer(1, 2'h1, 64'h0, 64'h0, 1);
    xfer(0, 2'h0, 64'h0, 64'h0000_0005_0000_0004, 0);
    xfer(1, 2'h2, 64'h00F, 64'h0, 0);
    xfer(0, 2'h2, 64'h0, 64'h00F, 0);
    xfer(1, 2'h0, 64'h0000_000F_0000_0001, 64'h0, 0);
    highestTag = 10'h00E;
    xfer(0, 2'h1, 64'h0, errFlag, 0);
  endtask
  always @(posedge refClk)
    if (++cycles == 500)
      test_done(1'b1);
  initial
  begin
    repeat (20) @(posedge refClk);
    #1 rst = 1'b0;
    t_codes;
    t_refuse;
    test_done(1'b0);
  end
endmodule // tb_shared_cache_monitor_readout
`default_nettype wire
